// File: dpl_link_manager.sv
// dpl_link_manager: dynamic-poll link management for one radio circuit
// assumes link events arrive as one-cycle pulses synchronous to clk_in
`timescale 1ns/1ps
module dpl_link_manager #(
  parameter int unsigned TICK_CYCLES = dpl_pkg::UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb register port
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // link events from the radio side
  input wire logic link_activity_in,
  input wire logic poll_cycle_in,
  input wire logic tx_attempt_in,
  input wire logic tx_ack_in,
  input wire logic special_ack_in,
  input wire logic upload_pending_in,
  // link actions toward the radio side
  output logic poll_out,
  output logic retx_allow_out,
  output logic special_req_out,
  output logic drop_req_out,
  output logic wake_out,
  output logic test_out,
  output logic circuit_active_out,
  output logic dynamic_poll_protocol_out
);
  // ----------------------------------------------------------------
  // registers and internal state
  // ----------------------------------------------------------------
  logic dyn_q;
  logic master_q;
  logic [7:0] lat_q;
  logic [7:0] drop_code_q;
  logic [7:0] test_code_q;
  logic [2:0] retry_lim_q;
  logic [2:0] skip_q;
  logic [23:0] tick_cnt_q;
  logic tick_q;
  dpl_pkg::dpl_state_t st_q;
  logic [2:0] retry_cnt_q;
  logic grant_q;
  logic [7:0] lat_cnt_q;
  logic [6:0] cyc_q;
  logic [2:0] skip_n;
  logic [6:0] skip_mask;
  logic over_lim;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] rd_data;

  dpl_tmr_if drop_t ();
  dpl_tmr_if test_t ();

  // ----------------------------------------------------------------
  // apb slave: no wait states, read data captured in setup
  // ----------------------------------------------------------------
  assign rd_setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in && addr_ok;
  assign addr_ok = (paddr_in == dpl_pkg::OFS_CTRL) || (paddr_in == dpl_pkg::OFS_LAT) ||
                   (paddr_in == dpl_pkg::OFS_PARAM) || (paddr_in == dpl_pkg::OFS_STAT);

  always_comb begin
    rd_data = 32'h0;
    case (paddr_in)
      dpl_pkg::OFS_CTRL: begin
        rd_data[dpl_pkg::CTRL_DYN_BIT] = dyn_q;
        rd_data[dpl_pkg::CTRL_MASTER_BIT] = master_q;
      end
      dpl_pkg::OFS_LAT: begin
        rd_data[7:0] = lat_q;
      end
      dpl_pkg::OFS_PARAM: begin
        rd_data[dpl_pkg::PRM_DROP_LSB +: 8] = drop_code_q;
        rd_data[dpl_pkg::PRM_TEST_LSB +: 8] = test_code_q;
        rd_data[dpl_pkg::PRM_RETRY_LSB +: 3] = retry_lim_q;
        rd_data[dpl_pkg::PRM_SKIP_LSB +: 3] = skip_q;
      end
      dpl_pkg::OFS_STAT: begin
        rd_data = {19'h0, skip_n, grant_q, retry_cnt_q, 2'(st_q), 1'b0, drop_t.expired,
                   test_t.expired, circuit_active_out};
      end
      default: begin
        rd_data = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= rd_setup;
      // error flag stands only alongside the answer
      pslverr_out <= rd_setup && !addr_ok;
      if (rd_setup) begin
        prdata_out <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dyn_q <= dpl_pkg::CTRL_DYN_RST;
      master_q <= dpl_pkg::CTRL_MASTER_RST;
      lat_q <= dpl_pkg::LAT_DEF;
      drop_code_q <= dpl_pkg::DROP_RST;
      test_code_q <= dpl_pkg::TEST_RST;
      retry_lim_q <= dpl_pkg::RETRY_RST;
      skip_q <= dpl_pkg::SKIP_RST;
    end else if (wr_en) begin
      case (paddr_in)
        dpl_pkg::OFS_CTRL: begin
          dyn_q <= pwdata_in[dpl_pkg::CTRL_DYN_BIT];
          master_q <= pwdata_in[dpl_pkg::CTRL_MASTER_BIT];
        end
        dpl_pkg::OFS_LAT: begin
          lat_q <= pwdata_in[7:0];
        end
        dpl_pkg::OFS_PARAM: begin
          drop_code_q <= pwdata_in[dpl_pkg::PRM_DROP_LSB +: 8];
          test_code_q <= pwdata_in[dpl_pkg::PRM_TEST_LSB +: 8];
          retry_lim_q <= pwdata_in[dpl_pkg::PRM_RETRY_LSB +: 3];
          skip_q <= pwdata_in[dpl_pkg::PRM_SKIP_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  assign dynamic_poll_protocol_out = dyn_q;

  // ----------------------------------------------------------------
  // 10 ms time base
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tick_cnt_q <= 24'h0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 24'h0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // retry counting and special request
  // ----------------------------------------------------------------
  assign over_lim = retry_cnt_q >= retry_lim_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !dyn_q || tx_ack_in) begin
      retry_cnt_q <= 3'h0;
    end else if (tx_attempt_in && retry_cnt_q != dpl_pkg::RETRY_SAT) begin
      retry_cnt_q <= retry_cnt_q + 3'h1;
    end
  end

  // a granted special request allows exactly one more send
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !dyn_q || tx_ack_in) begin
      grant_q <= 1'b0;
    end else if (special_ack_in) begin
      grant_q <= 1'b1;
    end else if (tx_attempt_in) begin
      grant_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      retx_allow_out <= 1'b1;
      special_req_out <= 1'b0;
    end else begin
      retx_allow_out <= !dyn_q || !over_lim || grant_q;
      special_req_out <= dyn_q && over_lim && !grant_q && tx_attempt_in;
    end
  end

  // ----------------------------------------------------------------
  // poll skipping on the master
  // ----------------------------------------------------------------
  always_comb begin
    skip_n = 3'h0;
    if (retry_cnt_q > retry_lim_q) begin
      skip_n = retry_cnt_q - retry_lim_q;
    end
    if (skip_n > skip_q) begin
      skip_n = skip_q;
    end
    skip_mask = 7'((8'h1 << skip_n) - 8'h1);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cyc_q <= 7'h0;
      poll_out <= 1'b0;
    end else begin
      poll_out <= 1'b0;
      if (poll_cycle_in && master_q && circuit_active_out) begin
        cyc_q <= cyc_q + 7'h1;
        poll_out <= !dyn_q || ((cyc_q & skip_mask) == 7'h0);
      end
    end
  end

  // ----------------------------------------------------------------
  // drop and test timers
  // ----------------------------------------------------------------
  assign drop_t.tick = tick_q;
  assign drop_t.code = drop_code_q;
  assign drop_t.run = dyn_q && (st_q == dpl_pkg::ST_ACTIVE);
  // master clock starts only once no retries are in flight or the limit is reached
  assign drop_t.restart = link_activity_in ||
                          (master_q && retry_cnt_q != 3'h0 && !over_lim);

  assign test_t.tick = tick_q;
  assign test_t.code = test_code_q;
  assign test_t.run = dyn_q && !master_q && (st_q != dpl_pkg::ST_ACTIVE);
  assign test_t.restart = test_out || link_activity_in || master_q;

  dpl_interval_timer u_drop_tmr (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .t(drop_t.tmr)
  );

  dpl_interval_timer u_test_tmr (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .t(test_t.tmr)
  );

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !dyn_q) begin
      st_q <= dpl_pkg::ST_ACTIVE;
    end else begin
      case (st_q)
        dpl_pkg::ST_ACTIVE: begin
          if (drop_t.expired) begin
            st_q <= master_q ? dpl_pkg::ST_DROPPED : dpl_pkg::ST_DROP_REQ;
          end
        end
        dpl_pkg::ST_DROP_REQ: begin
          st_q <= dpl_pkg::ST_DROPPED;
        end
        dpl_pkg::ST_DROPPED: begin
          if (link_activity_in) begin
            st_q <= dpl_pkg::ST_ACTIVE;
          end else if (!master_q && upload_pending_in) begin
            st_q <= dpl_pkg::ST_WAKE;
          end
        end
        dpl_pkg::ST_WAKE: begin
          if (link_activity_in) begin
            st_q <= dpl_pkg::ST_ACTIVE;
          end else if (!upload_pending_in) begin
            st_q <= dpl_pkg::ST_DROPPED;
          end
        end
        default: begin
          st_q <= dpl_pkg::ST_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // remote signalling: drop request, paced wake, link test
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || st_q != dpl_pkg::ST_WAKE) begin
      lat_cnt_q <= 8'h0;
    end else if (lat_cnt_q == 8'h0) begin
      if (!wake_out) begin
        lat_cnt_q <= lat_q;
      end
    end else if (tick_q) begin
      lat_cnt_q <= lat_cnt_q - 8'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      drop_req_out <= 1'b0;
      wake_out <= 1'b0;
      test_out <= 1'b0;
      circuit_active_out <= 1'b1;
    end else begin
      drop_req_out <= dyn_q && !master_q && (st_q == dpl_pkg::ST_DROP_REQ);
      // one wake pulse per latency period while waiting for the master
      wake_out <= dyn_q && (st_q == dpl_pkg::ST_WAKE) && lat_cnt_q == 8'h0 && !wake_out;
      test_out <= dyn_q && test_t.expired && !test_out;
      // only real traffic, the drop timer and clearing dynamic mode change status, never a test result
      circuit_active_out <= !dyn_q || st_q == dpl_pkg::ST_ACTIVE;
    end
  end
endmodule // dpl_link_manager

// File: dpl_pkg.sv
// dpl_pkg: constants shared by the dynamic-poll link manager files
// assumes a 125 MHz system clock and a 32-bit APB register port
package dpl_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned UNIT_MS = 10;
  localparam int unsigned UNIT_CYCLES = UNIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W = 20;
  localparam int unsigned LAT_DEF_MS = 100;
  localparam logic [7:0] LAT_DEF = 8'(LAT_DEF_MS / UNIT_MS);
  localparam logic [4:0] MANT_BASE = 5'h10;
  localparam logic [2:0] RETRY_SAT = 3'h7;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAT = 8'h04;
  localparam logic [7:0] OFS_PARAM = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_DYN_BIT = 0;
  localparam int unsigned CTRL_MASTER_BIT = 1;
  localparam logic CTRL_DYN_RST = 1'b1;
  localparam logic CTRL_MASTER_RST = 1'b1;
  localparam int unsigned PRM_DROP_LSB = 0;
  localparam int unsigned PRM_TEST_LSB = 8;
  localparam int unsigned PRM_RETRY_LSB = 16;
  localparam int unsigned PRM_SKIP_LSB = 20;
  localparam logic [7:0] DROP_RST = 8'h80;
  localparam logic [7:0] TEST_RST = 8'h60;
  localparam logic [2:0] RETRY_RST = 3'h3;
  localparam logic [2:0] SKIP_RST = 3'h2;

  // ----------------------------------------------------------------
  // link state, gray along active -> drop request -> dropped -> wake
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_DROP_REQ = 2'h1,
    ST_DROPPED = 2'h3,
    ST_WAKE = 2'h2
  } dpl_state_t;
endpackage

// File: dpl_tmr_if.sv
// dpl_tmr_if: control and result of one log-scale interval timer
// assumes the owner drives all controls from the system clock domain
`timescale 1ns/1ps
interface dpl_tmr_if;
  logic restart;
  logic run;
  logic tick;
  logic [7:0] code;
  logic expired;
  modport ctl (output restart, output run, output tick, output code, input expired);
  modport tmr (input restart, input run, input tick, input code, output expired);
endinterface // dpl_tmr_if

// File: dpl_interval_timer.sv
// dpl_interval_timer: counts 10 ms ticks up to a time decoded from an 8-bit code
// assumes tick is a one-cycle pulse and restart is synchronous
`timescale 1ns/1ps
module dpl_interval_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // control and result
  dpl_tmr_if.tmr t
);
  logic [dpl_pkg::TMR_W-1:0] cnt_q;
  logic [dpl_pkg::TMR_W-1:0] limit;
  logic exp_q;

  // ----------------------------------------------------------------
  // code to tick count: (16 + mantissa) << exponent
  // ----------------------------------------------------------------
  always_comb begin
    limit = dpl_pkg::TMR_W'(dpl_pkg::MANT_BASE + 5'(t.code[3:0])) << t.code[7:4];
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || t.restart) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (t.run && t.tick && !exp_q) begin
      if (cnt_q == limit - dpl_pkg::TMR_W'(1)) begin
        exp_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + dpl_pkg::TMR_W'(1);
      end
    end
  end

  assign t.expired = exp_q;
endmodule // dpl_interval_timer

// File: dpl_link_manager_chk.sv
// dpl_link_manager_chk: port checks for the dynamic-poll link manager
// assumes latency and skip stay at their reset values while gaps are judged
`timescale 1ns/1ps
module dpl_link_manager_chk #(
  parameter int unsigned TICK_CYCLES = dpl_pkg::UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // link events
  input wire logic link_activity_in,
  input wire logic poll_cycle_in,
  input wire logic tx_attempt_in,
  input wire logic tx_ack_in,
  input wire logic special_ack_in,
  input wire logic upload_pending_in,
  // link actions
  input wire logic poll_out,
  input wire logic retx_allow_out,
  input wire logic special_req_out,
  input wire logic drop_req_out,
  input wire logic wake_out,
  input wire logic test_out,
  input wire logic circuit_active_out,
  input wire logic dynamic_poll_protocol_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  localparam int unsigned WAKE_GAP = dpl_pkg::LAT_DEF * TICK_CYCLES;
  logic [31:0] gap_q;
  logic [3:0] miss_q;
  // cycles since the last wake pulse of this episode
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || circuit_active_out) gap_q <= 32'hffffffff;
    else if (wake_out) gap_q <= 32'h0;
    else if (gap_q != 32'hffffffff) gap_q <= gap_q + 32'h1;
  end
  // poll cycles passed since the circuit was last polled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !circuit_active_out || !dynamic_poll_protocol_out) miss_q <= 4'h0;
    else if (poll_out) miss_q <= {3'h0, poll_cycle_in};
    else if (poll_cycle_in && miss_q != 4'hf) miss_q <= miss_q + 4'h1;
  end
  sequence dyn_off_held;
    !dynamic_poll_protocol_out [*3];
  endsequence
  sequence grant_seen;
    special_ack_in && dynamic_poll_protocol_out;
  endsequence
  AST_APB_ANSWER: assert property (psel_in && !penable_in |=> pready_out)
    else $error("apb access not answered at once");
  AST_APB_QUIET: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside an access phase");
  AST_APB_ERR: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error response carries data");
  AST_DYN_OFF: assert property (dyn_off_held |-> retx_allow_out && circuit_active_out &&
    !(drop_req_out || wake_out || test_out || special_req_out))
    else $error("link actions while dynamic mode off");
  AST_SPECIAL_CAUSE: assert property (special_req_out |-> $past(tx_attempt_in) && !retx_allow_out)
    else $error("special request without a blocked attempt");
  AST_GRANT: assert property (grant_seen |-> ##[1:2] retx_allow_out)
    else $error("acknowledged special request gave no send");
  AST_POLL_CAUSE: assert property (poll_out |-> $past(poll_cycle_in))
    else $error("poll outside a poll cycle");
  AST_POLL_GAP: assert property (miss_q <= 4'h4)
    else $error("active circuit skipped more than four poll cycles");
  AST_WAKE_IDLE: assert property (wake_out |-> !circuit_active_out)
    else $error("wake signal while circuit active");
  AST_WAKE_GAP: assert property (wake_out |-> gap_q >= WAKE_GAP - 1)
    else $error("wake signals closer than the latency");
endmodule // dpl_link_manager_chk

// File: dpl_peer_model.sv
// dpl_peer_model: far radio station answering the link manager
// assumes one-cycle request pulses on the system clock
`timescale 1ns/1ps
module dpl_peer_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pacing
  input wire logic [3:0] delay_in,
  input wire logic answer_en_in,
  // requests in, answers out
  input wire logic special_req_in,
  input wire logic wake_in,
  input wire logic test_in,
  output logic special_ack_out,
  output logic link_activity_out
);
  logic [4:0] ack_q;
  logic [4:0] act_q;
  // acknowledge each special request delay_in + 1 cycles after it is seen
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) ack_q <= 5'h0;
    else if (special_req_in) ack_q <= {1'b0, delay_in} + 5'h1;
    else if (ack_q != 5'h0) ack_q <= ack_q - 5'h1;
  end
  always_ff @(posedge clk_in) special_ack_out <= !sys_rst_in && ack_q == 5'h1;
  // answer wake or link test with traffic only when in range
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) act_q <= 5'h0;
    else if ((wake_in || test_in) && answer_en_in) act_q <= {1'b0, delay_in} + 5'h1;
    else if (act_q != 5'h0) act_q <= act_q - 5'h1;
  end
  always_ff @(posedge clk_in) link_activity_out <= !sys_rst_in && act_q == 5'h1;
endmodule // dpl_peer_model

// File: dpl_link_manager_tb.sv
// dpl_link_manager_tb: self-checking bench for the link manager
// assumes the peer model answers special requests, wake and test signals
`timescale 1ns/1ps
module dpl_link_manager_tb;
  localparam int PER = 10 * 4;
  logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, answer_en, er;
  logic link_activity_in, poll_cycle_in, tx_attempt_in, tx_ack_in, special_ack_in, upload_pending_in;
  logic poll_out, retx_allow_out, special_req_out, drop_req_out, wake_out, test_out;
  logic circuit_active_out, dynamic_poll_protocol_out;
  logic [3:0] delay;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  int n_mismatch, n_checks, n_poll, n_spec, n_wake, n_test;
  dpl_link_manager #(.TICK_CYCLES(4)) i_dpl_link_manager (.*);
  dpl_peer_model i_dpl_peer_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .delay_in(delay),
    .answer_en_in(answer_en), .special_req_in(special_req_out), .wake_in(wake_out), .test_in(test_out),
    .special_ack_out(special_ack_in), .link_activity_out(link_activity_in));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    n_poll += int'(poll_out === 1'b1);
    n_spec += int'(special_req_out === 1'b1);
    n_wake += int'(wake_out === 1'b1);
    n_test += int'(test_out === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hold(ref logic s, input logic v, input int lim, input string nm);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk_in);
      k++;
    end
    chk(nm, 32'(v), 32'(s));
    if (k >= lim) end_of_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    hold(pready_out, 1'b1, 16, "apb answer");
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic ev(input logic [2:0] m, input int n);
    repeat (n) begin
      {poll_cycle_in, tx_attempt_in, tx_ack_in} <= m;
      @(posedge clk_in);
      {poll_cycle_in, tx_attempt_in, tx_ack_in} <= 3'h0;
      @(posedge clk_in);
    end
  endtask
  task automatic rst();
    sys_rst_in <= 1'b1;
    answer_en <= 1'b0;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic s_regs();
    apb(1'b0, dpl_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h00000003, rd);
    apb(1'b0, dpl_pkg::OFS_LAT, 32'h0);
    chk("latency", 32'h0000000a, rd);
    apb(1'b0, dpl_pkg::OFS_PARAM, 32'h0);
    chk("param", 32'h00236080, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
  endtask
  task automatic s_dyn_off();
    apb(1'b1, dpl_pkg::OFS_CTRL, 32'h2);
    n_poll = 0;
    n_spec = 0;
    ev(3'h4, 4);
    ev(3'h2, 5);
    chk("dyn out", 32'h0, 32'(dynamic_poll_protocol_out));
    chk("polls", 32'h4, 32'(n_poll));
    chk("specials", 32'h0, 32'(n_spec));
    chk("retx open", 32'h1, 32'(retx_allow_out));
  endtask
  task automatic s_retry();
    rst();
    delay <= 4'h9;
    ev(3'h2, 3);
    @(posedge clk_in);
    chk("retx at limit", 32'h0, 32'(retx_allow_out));
    n_spec = 0;
    ev(3'h2, 1);
    hold(retx_allow_out, 1'b1, 30, "grant");
    delay <= 4'h0;
    repeat (6) begin
      ev(3'h2, 1);
      repeat (6) @(posedge clk_in);
    end
    chk("special count", 32'h4, 32'(n_spec));
    apb(1'b0, dpl_pkg::OFS_STAT, 32'h0);
    chk("retry count", 32'h7, 32'(rd[8:6]));
    chk("skip", 32'h2, 32'(rd[12:10]));
    n_poll = 0;
    ev(3'h4, 8);
    repeat (2) @(posedge clk_in);
    chk("skipped polls", 32'h2, 32'(n_poll));
    ev(3'h1, 1);
    apb(1'b0, dpl_pkg::OFS_STAT, 32'h0);
    chk("retry cleared", 32'h0, 32'(rd[8:6]));
  endtask
  task automatic s_master_drop();
    rst();
    n_test = 0;
    apb(1'b1, dpl_pkg::OFS_PARAM, 32'h00230000);
    repeat (44) @(posedge clk_in);
    chk("still active", 32'h1, 32'(circuit_active_out));
    hold(circuit_active_out, 1'b0, 40, "master drop");
    chk("master tests", 32'h0, 32'(n_test));
  endtask
  task automatic s_remote();
    rst();
    apb(1'b1, dpl_pkg::OFS_PARAM, 32'h00230000);
    apb(1'b1, dpl_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, dpl_pkg::OFS_LAT, 32'h0);
    chk("remote latency", 32'h0000000a, rd);
    hold(drop_req_out, 1'b1, 120, "drop request");
    hold(test_out, 1'b1, 300, "link test");
    hold(circuit_active_out, 1'b0, 300, "remote dropped");
    upload_pending_in <= 1'b1;
    hold(wake_out, 1'b1, 20, "wake");
    @(posedge clk_in);
    n_wake = 0;
    repeat (2 * PER + 2) @(posedge clk_in);
    chk("wake pace", 32'h2, 32'(n_wake));
    answer_en <= 1'b1;
    hold(circuit_active_out, 1'b1, PER + 10, "reactivated");
    upload_pending_in <= 1'b0;
  endtask
  initial begin
    {sys_rst_in, psel_in, penable_in, pwrite_in, answer_en, upload_pending_in} = 6'h20;
    {poll_cycle_in, tx_attempt_in, tx_ack_in} = 3'h0;
    paddr_in = 8'h0;
    pwdata_in = 32'h0;
    delay = 4'h3;
    rst();
    s_regs();
    s_dyn_off();
    s_retry();
    s_master_drop();
    s_remote();
    end_of_test();
  end
endmodule // dpl_link_manager_tb
bind dpl_link_manager dpl_link_manager_chk #(.TICK_CYCLES(TICK_CYCLES)) i_dpl_link_manager_chk (.*);
